// file: src/scpm_pin_mux.v
// Pin function selection for serial channels 0 and 1 with register port
`timescale 1ns/100ps
`default_nettype none
`include "scpm_regs.vh"
module scpm_pin_mux (
  input  wire       clk,
  input  wire       rst,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // Serial engine side
  input  wire       engine_clock_level,
  input  wire       engine_data_level,
  output wire       clocked_rx_data,
  output wire       async_rx_data,
  output wire       clocked_clock_in,
  // Port/interrupt side
  output wire       ext_interrupt_a,
  output wire       ext_interrupt_b,
  // Pins: in, out, output enable
  input  wire       serial_clock_pin_in,
  output wire       serial_clock_pin_out,
  output wire       serial_clock_pin_oe,
  input  wire       serial_input_pin_in,
  output wire       serial_input_pin_out,
  output wire       serial_input_pin_oe,
  input  wire       serial_output_pin_in,
  output wire       serial_output_pin_out,
  output wire       serial_output_pin_oe
);

  reg  [1:0] unit_enable_status;
  reg  [1:0] next_unit_enable_status;
  wire [4:0] ch0_mode;
  wire [4:0] ch1_mode;
  wire [2:0] out_ctrl;
  wire [2:0] port_dir;
  wire [2:0] port_latch;
  wire [2:0] pin_in;
  wire       wr_start;
  wire       wr_stop;
  wire       wr_ch0_mode;
  wire       wr_ch1_mode;
  wire       wr_out_ctrl;
  wire       wr_port_dir;
  wire       wr_port_latch;

  assign pin_in = {serial_output_pin_in, serial_input_pin_in, serial_clock_pin_in};

  // One strobe per writable register; status, pin state and unmapped addresses fall through
  assign wr_start      = wr && (addr == `SCPM_A_START_TRIG);
  assign wr_stop       = wr && (addr == `SCPM_A_STOP_TRIG);
  assign wr_ch0_mode   = wr && (addr == `SCPM_A_CH0_MODE);
  assign wr_ch1_mode   = wr && (addr == `SCPM_A_CH1_MODE);
  assign wr_out_ctrl   = wr && (addr == `SCPM_A_OUT_CTRL);
  assign wr_port_dir   = wr && (addr == `SCPM_A_PORT_DIR);
  assign wr_port_latch = wr && (addr == `SCPM_A_PORT_LATCH);

  // Triggers act as set and clear masks; status itself ignores writes
  always @* begin
    next_unit_enable_status = unit_enable_status;
    if (wr_start) begin
      next_unit_enable_status = unit_enable_status | wdata[1:0];
    end else if (wr_stop) begin
      next_unit_enable_status = unit_enable_status & ~wdata[1:0];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      unit_enable_status <= `SCPM_STATUS_RST;
    end else begin
      unit_enable_status <= next_unit_enable_status;
    end
  end

  // Channel 0 mode: function, enables, master
  scpm_cfg_reg #(
    .WIDTH (`SCPM_MODE_W),
    .RESET (`SCPM_MODE_RST)
  ) i_ch0_mode (
    .clk   (clk),
    .rst   (rst),
    .load  (wr_ch0_mode),
    .value (wdata[4:0]),
    .q     (ch0_mode)
  );

  // Channel 1 mode: resets into stopped async function
  scpm_cfg_reg #(
    .WIDTH (`SCPM_MODE_W),
    .RESET (`SCPM_CH1_MODE_RST)
  ) i_ch1_mode (
    .clk   (clk),
    .rst   (rst),
    .load  (wr_ch1_mode),
    .value (wdata[4:0]),
    .q     (ch1_mode)
  );

  // Output control: enable, data level, clock level
  scpm_cfg_reg #(
    .WIDTH (`SCPM_CTRL_W),
    .RESET (`SCPM_OUT_RST)
  ) i_out_ctrl (
    .clk   (clk),
    .rst   (rst),
    .load  (wr_out_ctrl),
    .value (wdata[2:0]),
    .q     (out_ctrl)
  );

  // Pin directions; all pins come out of reset as inputs
  scpm_cfg_reg #(
    .WIDTH (`SCPM_CTRL_W),
    .RESET (`SCPM_DIR_RST)
  ) i_port_dir (
    .clk   (clk),
    .rst   (rst),
    .load  (wr_port_dir),
    .value (wdata[2:0]),
    .q     (port_dir)
  );

  scpm_cfg_reg #(
    .WIDTH (`SCPM_CTRL_W),
    .RESET (`SCPM_LATCH_RST)
  ) i_port_latch (
    .clk   (clk),
    .rst   (rst),
    .load  (wr_port_latch),
    .value (wdata[2:0]),
    .q     (port_latch)
  );

  // Decoded channel state
  wire [1:0] ch0_md;
  wire [1:0] ch1_md;
  wire       ch0_on;
  wire       ch1_on;
  wire       ch0_txe;
  wire       ch0_rxe;
  wire       ch1_rxe;
  wire       master;
  wire       serial_output_enable;

  assign ch0_md  = ch0_mode[`SCPM_MD_HI:`SCPM_MD_LO];
  assign ch1_md  = ch1_mode[`SCPM_MD_HI:`SCPM_MD_LO];
  assign ch0_on  = unit_enable_status[`SCPM_CH0];
  assign ch1_on  = unit_enable_status[`SCPM_CH1];
  assign ch0_txe = ch0_mode[`SCPM_TXE_BIT];
  assign ch0_rxe = ch0_mode[`SCPM_RXE_BIT];
  assign ch1_rxe = ch1_mode[`SCPM_RXE_BIT];
  assign master  = ch0_mode[`SCPM_MASTER_BIT];
  assign serial_output_enable     = out_ctrl[`SCPM_SOE_BIT];

  wire       csi_on;
  wire       uart_tx_on;
  wire       uart_rx_on;
  wire       csi_rx_on;
  wire       sck_out_on;
  wire       so_on;
  wire       clk_level;
  wire       so_level;
  wire       serial_owns_in;

  assign csi_on     = ch0_on && (ch0_md == `SCPM_MD_CSI);
  assign uart_tx_on = ch0_on && (ch0_md == `SCPM_MD_UART) && ch0_txe;
  // Clocked mode takes priority over async receive on the shared input
  assign uart_rx_on = ch1_on && (ch1_md == `SCPM_MD_UART) && ch1_rxe && !csi_on;
  assign csi_rx_on  = csi_on && ch0_rxe;
  assign sck_out_on = csi_on && master;
  assign so_on      = (csi_on && ch0_txe && serial_output_enable) || (uart_tx_on && serial_output_enable);
  assign serial_owns_in = csi_rx_on | uart_rx_on;

  // Clock level held high in slave and async modes
  assign clk_level = sck_out_on ? (engine_clock_level & out_ctrl[`SCPM_CKO_BIT]) : 1'b1;
  assign so_level  = so_on ? engine_data_level : out_ctrl[`SCPM_SO_BIT];

  // Clock pin: master clock out, else port latch per direction
  scpm_pin_cell i_clock_pin (
    .serial_drive (sck_out_on),
    .serial_level (clk_level),
    .serial_claim (1'b0),
    .dir_input    (port_dir[`SCPM_PIN_CLK]),
    .latch_level  (port_latch[`SCPM_PIN_CLK]),
    .pin_out      (serial_clock_pin_out),
    .pin_oe       (serial_clock_pin_oe)
  );

  // Input pin: never driven while a receiver listens on it
  scpm_pin_cell i_input_pin (
    .serial_drive (1'b0),
    .serial_level (1'b1),
    .serial_claim (serial_owns_in),
    .dir_input    (port_dir[`SCPM_PIN_IN]),
    .latch_level  (port_latch[`SCPM_PIN_IN]),
    .pin_out      (serial_input_pin_out),
    .pin_oe       (serial_input_pin_oe)
  );

  // Output pin: serial data when transmitting with output enabled
  scpm_pin_cell i_output_pin (
    .serial_drive (so_on),
    .serial_level (so_level),
    .serial_claim (1'b0),
    .dir_input    (port_dir[`SCPM_PIN_OUT]),
    .latch_level  (port_latch[`SCPM_PIN_OUT]),
    .pin_out      (serial_output_pin_out),
    .pin_oe       (serial_output_pin_oe)
  );

  // Inputs gated so idle engines see a quiet line
  assign clocked_clock_in = (csi_on && !master) ? serial_clock_pin_in : 1'b1;
  assign clocked_rx_data  = csi_rx_on ? serial_input_pin_in : 1'b1;
  assign async_rx_data    = uart_rx_on ? serial_input_pin_in : 1'b1;
  // Interrupt paths only while the pin is not a serial function
  assign ext_interrupt_a  = csi_on ? 1'b0 : serial_clock_pin_in;
  assign ext_interrupt_b  = serial_owns_in ? 1'b0 : serial_input_pin_in;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= `SCPM_ZERO;
    end else if (rd) begin
      case (addr)
        `SCPM_A_ENABLE_STATUS: begin
          rdata <= {6'h00, unit_enable_status};
        end
        `SCPM_A_CH0_MODE: begin
          rdata <= {3'h0, ch0_mode};
        end
        `SCPM_A_CH1_MODE: begin
          rdata <= {3'h0, ch1_mode};
        end
        `SCPM_A_OUT_CTRL: begin
          rdata <= {5'h00, out_ctrl};
        end
        `SCPM_A_PORT_DIR: begin
          rdata <= {5'h00, port_dir};
        end
        `SCPM_A_PORT_LATCH: begin
          rdata <= {5'h00, port_latch};
        end
        `SCPM_A_PIN_STATE: begin
          rdata <= {5'h00, pin_in};
        end
        default: begin
          rdata <= `SCPM_ZERO;
        end
      endcase
    end else begin
      // Zero outside the read slot, so stale data never lingers
      rdata <= `SCPM_ZERO;
    end
  end

endmodule // scpm_pin_mux

// Loadable configuration register with asynchronous reset
module scpm_cfg_reg #(
  parameter             WIDTH = 5,
  parameter [WIDTH-1:0] RESET = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             load,
  input  wire [WIDTH-1:0] value,
  output reg  [WIDTH-1:0] q
);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RESET;
    end else if (load) begin
      q <= value;
    end
  end

endmodule // scpm_cfg_reg

// One shared pin: serial function, else port latch when set as output
module scpm_pin_cell (
  input  wire serial_drive,
  input  wire serial_level,
  input  wire serial_claim,
  input  wire dir_input,
  input  wire latch_level,
  output wire pin_out,
  output wire pin_oe
);

  assign pin_out = serial_drive ? serial_level : latch_level;
  // A receiver claiming the pin keeps the port latch off it
  assign pin_oe  = serial_drive | (~dir_input & ~serial_claim);

endmodule // scpm_pin_cell
`default_nettype wire

// file: shared/scpm_regs.vh
// Register map, field positions and encodings of the serial pin mux
`ifndef SCPM_REGS_VH
`define SCPM_REGS_VH
`define SCPM_ADDR_W          4
`define SCPM_DATA_W          8
`define SCPM_ZERO            8'h00
// Register addresses
`define SCPM_A_ENABLE_STATUS 4'h0
`define SCPM_A_START_TRIG    4'h1
`define SCPM_A_STOP_TRIG     4'h2
`define SCPM_A_CH0_MODE      4'h3
`define SCPM_A_CH1_MODE      4'h4
`define SCPM_A_OUT_CTRL      4'h5
`define SCPM_A_PORT_DIR      4'h6
`define SCPM_A_PORT_LATCH    4'h7
`define SCPM_A_PIN_STATE     4'h8
// Channel bit positions in status and trigger registers
`define SCPM_CH0             0
`define SCPM_CH1             1
// Mode register fields
`define SCPM_MD_LO           0
`define SCPM_MD_HI           1
`define SCPM_TXE_BIT         2
`define SCPM_RXE_BIT         3
`define SCPM_MASTER_BIT      4
// Output control fields
`define SCPM_SOE_BIT         0
`define SCPM_SO_BIT          1
`define SCPM_CKO_BIT         2
// Port bits: clock, input, output pins
`define SCPM_PIN_CLK         0
`define SCPM_PIN_IN          1
`define SCPM_PIN_OUT         2
// Function select codes
`define SCPM_MD_CSI          2'h0
`define SCPM_MD_UART         2'h1
// Reset values
`define SCPM_MODE_RST        5'h00
`define SCPM_CH1_MODE_RST    5'h01
`define SCPM_OUT_RST         3'h6
`define SCPM_DIR_RST         3'h7
`define SCPM_LATCH_RST       3'h0
`define SCPM_STATUS_RST      2'h0
// Register widths
`define SCPM_MODE_W          5
`define SCPM_CTRL_W          3
`endif

// file: bench/scpm_peer.sv
// Far-side serial peer: clock only in frames, data line never still
`timescale 1ns/100ps
`default_nettype none
module scpm_peer (
  input  wire logic clk,
  input  wire logic frame,
  output logic      sclk,
  output logic      sdat
);
  initial sclk = 1'h1;
  initial sdat = 1'h0;
  // Toggling data so a stale pin value can never pass a compare
  always @(posedge clk) begin
    sclk <= frame ? ~sclk : 1'h1;
    sdat <= ~sdat;
  end
endmodule // scpm_peer
`default_nettype wire

// file: bench/scpm_pin_mux_properties.sv
// Port-level assertions for the serial pin mux
`timescale 1ns/100ps
`default_nettype none
module scpm_pin_mux_properties (
  input wire logic       clk, rst, rd,
  input wire logic [3:0] addr,
  input wire logic [7:0] rdata,
  input wire logic       clocked_rx_data, async_rx_data, ext_interrupt_a, ext_interrupt_b,
  input wire logic       serial_clock_pin_oe, serial_input_pin_oe, serial_output_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence trig_rd;
    rd && (addr == 4'h1 || addr == 4'h2);
  endsequence
  chk_trig_reads: assert property (trig_rd |=> rdata == 8'h00)
    else $error("trigger register read not zero");
  chk_idle_rdata: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  chk_reset_release: assert property ($past(rst) |-> !serial_clock_pin_oe &&
    !serial_input_pin_oe && !serial_output_pin_oe) else $error("pin driven after reset");
  chk_in_pin_owned: assert property (serial_input_pin_oe |-> clocked_rx_data && async_rx_data)
    else $error("input pin driven while receiving");
  chk_one_receiver: assert property (!async_rx_data |-> clocked_rx_data)
    else $error("both receivers fed");
  chk_clocked_intb: assert property (!clocked_rx_data |-> !ext_interrupt_b)
    else $error("interrupt b live in clocked receive");
  chk_async_intb: assert property (!async_rx_data |-> !ext_interrupt_b)
    else $error("interrupt b live in async receive");
  chk_clocked_inta: assert property (!clocked_rx_data |-> !ext_interrupt_a)
    else $error("interrupt a live in clocked mode");
endmodule // scpm_pin_mux_properties
bind scpm_pin_mux scpm_pin_mux_properties i_props (.*);
`default_nettype wire

// file: bench/scpm_pin_mux_bench.sv
// Self-checking bench for the serial pin mux
`timescale 1ns/100ps
`default_nettype none
module scpm_pin_mux_bench;
  logic       clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, ec = 1'h0, ed = 1'h0, frame = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  wire  [7:0] rdata;
  wire        crx, arx, ia, ib, cci, co, coe, io, ioe, oo, ooe, sclk, sdat;
  wire        w_clk = coe ? co : sclk;
  wire        w_in = ioe ? io : sdat;
  wire        w_out = ooe ? oo : ~sdat;
  int         miscompares = 0, num_checks = 0;
  always #20 clk = ~clk;
  scpm_peer i_peer (.clk(clk), .frame(frame), .sclk(sclk), .sdat(sdat));
  scpm_pin_mux i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .engine_clock_level(ec), .engine_data_level(ed), .clocked_rx_data(crx),
    .async_rx_data(arx), .clocked_clock_in(cci), .ext_interrupt_a(ia), .ext_interrupt_b(ib),
    .serial_clock_pin_in(w_clk), .serial_clock_pin_out(co), .serial_clock_pin_oe(coe),
    .serial_input_pin_in(w_in), .serial_input_pin_out(io), .serial_input_pin_oe(ioe),
    .serial_output_pin_in(w_out), .serial_output_pin_out(oo), .serial_output_pin_oe(ooe));
  task chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'h1};
    @(posedge clk) wr <= 1'h0;
    #1;
  endtask
  task rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) {addr, rd} <= {a, 1'h1};
    @(posedge clk) rd <= 1'h0;
    #1 chk(rdata, e);
  endtask
  task eng(input logic c, d);
    @(posedge clk) {ec, ed} <= {c, d};
    #1;
  endtask
  task t_status;
    rreg(4'h4, 8'h01); rreg(4'h5, 8'h06); rreg(4'h7, 8'h00);
    chk(coe | ioe | ooe, 8'h00);
    wreg(4'h0, 8'hff); rreg(4'h0, 8'h00);
    wreg(4'h1, 8'h01); rreg(4'h0, 8'h01); rreg(4'h1, 8'h00);
    rreg(4'hf, 8'h00);
    wreg(4'h2, 8'h01); rreg(4'h0, 8'h00);
  endtask
  task t_master;
    frame <= 1'h1;
    wreg(4'h3, 8'h18); wreg(4'h6, 8'h06); wreg(4'h7, 8'h01); wreg(4'h1, 8'h01);
    for (int i = 0; i < 2; i++) begin
      eng(i[0], 1'h0);
      chk(co, i[0]);
      chk(crx, w_in);
      chk(ia, 8'h00);
      chk(ib, 8'h00);
    end
    // Slave receive: peer clock reaches the engine, clock pin left undriven
    wreg(4'h3, 8'h08); wreg(4'h6, 8'h07);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) #1;
      chk({coe, cci}, {1'h0, w_clk});
    end
    // Receiver started against the rules: clocked side must keep the pin
    wreg(4'h4, 8'h09); wreg(4'h1, 8'h02); chk(arx, 8'h01);
    wreg(4'h2, 8'h03);
    frame <= 1'h0;
  endtask
  task t_async;
    wreg(4'h3, 8'h05); wreg(4'h5, 8'h07); wreg(4'h6, 8'h03); wreg(4'h7, 8'h04);
    wreg(4'h1, 8'h03);
    for (int i = 0; i < 2; i++) begin
      eng(1'h0, i[0]);
      chk(oo & ooe, i[0]);
      chk(arx, w_in);
      chk(ib, 8'h00);
      chk({crx, coe, ia}, {2'h2, w_clk});
    end
    wreg(4'h2, 8'h03); wreg(4'h6, 8'h00);
    chk({ooe, oo, ioe, coe, arx, crx}, 8'h3f);
  endtask
  task test_done;
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    t_status;
    t_master;
    t_async;
    test_done;
  end
  initial begin
    #100000;
    miscompares++;
    test_done;
  end
endmodule // scpm_pin_mux_bench
`default_nettype wire
